// ### core/wwt_top.sv
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Function
// R1: seven-stage prescaler feeding fifteen-stage counter, both on the system clock.
// R2: counter offers overflow taps at divide by 2^15, 2^17, 2^19, 2^21.
// R3: period codes 00..11 pick taps 2^15..2^21, timeout quadruples per step.
// R4: two-bit detection period field, reset to 00.
// R5: quick-count bit bypasses the seven-stage prescaler.
// R6: software keeps quick-count at 0 while used as watchdog.
// R7: overflow raises non-maskable interrupt and drives alarm output low.
// R8: software clears the counter before timeout in normal operation.
// R9: writing 4EH to command register clears counter, which then keeps counting.
// R10: alarm stays low until watchdog disabled and 4EH written, then high.
// R11: enable bit resets to 1, watchdog runs after reset.
// R12: disable only by clearing enable bit then writing B1H.
// R13: setting enable bit re-enables immediately, no code needed.
// R14: reset-link bit, reset to 0, routes alarm into internal reset.
// R15: with reset link, alarm held low 8 to 20 states then self reset.
// R16: counter starts counting as soon as reset is released.
// R17: counter halts in light idle and stop, counts in run and bus release.
// R18: deep idle keeps counting but suppresses overflow interrupt.
// R19: warm-up ends at stage 2^7 or 2^9 by warm-up select field.
// R20: quick-count 1 gives a 2^7 warm-up count.
// R21: shortened warm-up not selectable while watchdog operates.
module wwt_top #(
  parameter int PRE_W = wwt_pkg::PRE_STAGES,
  parameter int CNT_W = wwt_pkg::CNT_STAGES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        light_idle_mode,
  input  wire logic        stop_mode,
  input  wire logic        deep_idle_mode,
  input  wire logic        warmup_start,
  output logic             warmup_done,
  output logic             guard_overflow_irq,
  output logic             runaway_alarm_out_n,
  output logic             chip_reset_req
);

  // 0 mode, 1 command, 2 timer pair, 3 status, 4 unmapped
  function automatic logic [2:0] reg_sel(input logic [3:0] a);
    if (a == wwt_pkg::MODE_OFS) begin
      reg_sel = 3'h0;
    end else if (a == wwt_pkg::CMD_OFS) begin
      reg_sel = 3'h1;
    end else if (a == wwt_pkg::PAIR_OFS) begin
      reg_sel = 3'h2;
    end else if (a == wwt_pkg::STATUS_OFS) begin
      reg_sel = 3'h3;
    end else begin
      reg_sel = 3'h4;
    end
  endfunction

  // bus slave state
  logic        awready_reg, awready_next;
  logic        wready_reg, wready_next;
  logic        aw_have_reg, aw_have_next;
  logic        w_have_reg, w_have_next;
  logic [3:0]  awaddr_reg, awaddr_next;
  logic [7:0]  wbyte_reg, wbyte_next;
  logic        wlane_reg, wlane_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        arready_reg, arready_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;

  // core state
  wwt_pkg::wwt_mode_t  mode_reg, mode_next;
  logic                quick_reg, quick_next;
  logic                disarm_reg, disarm_next;
  logic [PRE_W-1:0]    pre_reg, pre_next;
  logic [CNT_W-1:0]    cnt_reg, cnt_next;
  wwt_pkg::wwt_state_t state_reg, state_next;
  logic [4:0]          hold_reg, hold_next;
  logic                warm_reg, warm_next;
  logic                wdone_reg, wdone_next;
  logic                wdone_flag_reg, wdone_flag_next;
  logic                irq_reg, irq_next;
  logic                alarm_n_reg, alarm_n_next;
  logic                rst_req_reg, rst_req_next;

  logic       wr_fire;
  logic [2:0] wr_sel;
  logic       wr_mode, wr_cmd, wr_pair;
  logic       guard_run, quick_eff, tick, count_en;
  logic       ovf, guard_event, warm_end;
  logic       cmd_clear, cmd_disable;
  logic [3:0] tap_full;
  logic [31:0] status_word;

  assign wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
  assign wr_sel  = reg_sel(awaddr_reg);
  assign wr_mode = wr_fire & wlane_reg & (wr_sel == 3'h0);
  assign wr_cmd  = wr_fire & wlane_reg & (wr_sel == 3'h1);
  assign wr_pair = wr_fire & wlane_reg & (wr_sel == 3'h2);
  // command codes decoded once, used by disarm, clear and alarm release
  assign cmd_clear   = wr_cmd & (wbyte_reg == wwt_pkg::CMD_CLEAR);
  assign cmd_disable = wr_cmd & (wbyte_reg == wwt_pkg::CMD_DISABLE);

  always_comb begin
    awready_next = awready_reg;
    wready_next  = wready_reg;
    aw_have_next = aw_have_reg;
    w_have_next  = w_have_reg;
    awaddr_next  = awaddr_reg;
    wbyte_next   = wbyte_reg;
    wlane_next   = wlane_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    // address and data may arrive in either order
    if (s_axi_awvalid && awready_reg) begin
      aw_have_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_have_next = 1'b1;
      wbyte_next  = s_axi_wdata[7:0];
      wlane_next  = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (wr_sel == 3'h4) ? wwt_pkg::RESP_SLVERR : wwt_pkg::RESP_OKAY;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // readies stay low while a response waits: one write in flight
    awready_next = ~aw_have_next & ~bvalid_next;
    wready_next  = ~w_have_next & ~bvalid_next;
    // unmapped reads answer with an error and zero data
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = wwt_pkg::RESP_OKAY;
      if (reg_sel(s_axi_araddr) == 3'h0) begin
        rdata_next = {24'h000000, mode_reg, 1'b0};
      end else if (reg_sel(s_axi_araddr) == 3'h2) begin
        rdata_next = {31'h0, quick_reg};
      end else if (reg_sel(s_axi_araddr) == 3'h3) begin
        rdata_next = status_word;
      end else if (reg_sel(s_axi_araddr) == 3'h1) begin
        // command register is write only
        rdata_next = 32'h00000000;
      end else begin
        rdata_next = 32'h00000000;
        rresp_next = wwt_pkg::RESP_SLVERR;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    arready_next = ~rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= 4'h0;
      wbyte_reg   <= 8'h00;
      wlane_reg   <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= 2'h0;
    end else if (ce) begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      aw_have_reg <= aw_have_next;
      w_have_reg  <= w_have_next;
      awaddr_reg  <= awaddr_next;
      wbyte_reg   <= wbyte_next;
      wlane_reg   <= wlane_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // one full-window flag per tap, code k watches 8+2k counter bits
  genvar gk;
  generate
    for (gk = 0; gk < 4; gk++) begin : g_tap
      assign tap_full[gk] = &cnt_reg[wwt_pkg::TAP_BASE + wwt_pkg::TAP_STEP*gk - 1:0]; // [R2] [R3]
    end
  endgenerate

  assign guard_run = ~disarm_reg;
  assign quick_eff = quick_reg & ~guard_run; // [R21]
  assign tick      = quick_eff | (&pre_reg); // [R1] [R5]
  // warm-up must run while leaving stop, otherwise halted in light idle and stop
  assign count_en  = warm_reg | ~(light_idle_mode | stop_mode); // [R17]
  assign ovf       = count_en & tick & tap_full[mode_reg.period];
  assign guard_event = guard_run & ovf & ~deep_idle_mode; // [R7] [R18]
  assign warm_end  = warm_reg & count_en & tick &
                     (quick_eff ? (&cnt_reg[wwt_pkg::WARM_SHORT-1:0]) :             // [R20]
                      mode_reg.warm_sel ? (&cnt_reg[wwt_pkg::WARM_LONG-1:0]) :
                                          (&cnt_reg[wwt_pkg::WARM_SHORT-1:0]));  // [R19]

  always_comb begin
    status_word = 32'h00000000;
    status_word[wwt_pkg::STAT_RUN_BIT]   = guard_run;
    status_word[wwt_pkg::STAT_ALARM_BIT] = ~alarm_n_reg;
    status_word[wwt_pkg::STAT_WARM_BIT]  = warm_reg;
    status_word[wwt_pkg::STAT_DONE_BIT]  = wdone_flag_reg;
    status_word[wwt_pkg::STAT_CNT_LSB +: CNT_W] = cnt_reg;
  end

  always_comb begin
    mode_next       = mode_reg;
    quick_next      = quick_reg;
    disarm_next     = disarm_reg;
    pre_next        = pre_reg;
    cnt_next        = cnt_reg;
    state_next      = state_reg;
    hold_next       = hold_reg;
    warm_next       = warm_reg;
    wdone_next      = 1'b0;
    wdone_flag_next = wdone_flag_reg;
    irq_next        = 1'b0;
    rst_req_next    = 1'b0;
    if (wr_mode) begin
      mode_next = wbyte_reg[7:1];
      // clearing enable alone never disarms; that needs the code too
      if (wbyte_reg[wwt_pkg::MODE_ENABLE_BIT]) begin
        disarm_next = 1'b0; // [R13]
      end
    end
    if (wr_pair) begin
      quick_next = wbyte_reg[wwt_pkg::PAIR_QUICK_BIT];
    end
    // code only counts when enable was already clear beforehand
    if (cmd_disable && !mode_reg.enable) begin
      disarm_next = 1'b1; // [R12]
    end
    if (count_en) begin
      if (quick_eff) begin
        pre_next = '0;
      end else begin
        pre_next = pre_reg + 1'b1;
      end
      if (tick) begin
        cnt_next = cnt_reg + 1'b1; // [R16]
      end
    end
    if (cmd_clear) begin
      pre_next = '0; // [R9]
      cnt_next = '0; // [R9]
    end
    if (warmup_start) begin
      pre_next  = '0;
      cnt_next  = '0;
      warm_next = 1'b1;
    end else if (warm_end) begin
      warm_next       = 1'b0;
      wdone_next      = 1'b1;
      wdone_flag_next = 1'b1;
    end
    // a finishing warm-up beats the clearing mode write
    if (wr_mode && !warm_end) begin
      wdone_flag_next = 1'b0;
    end
    case (state_reg)
      wwt_pkg::ST_IDLE: begin
        if (guard_event) begin
          irq_next = 1'b1; // [R7]
          if (mode_reg.rlink) begin
            state_next = wwt_pkg::ST_HOLD; // [R14]
            hold_next  = 5'd0;
          end else begin
            state_next = wwt_pkg::ST_ALARM;
          end
        end
      end
      wwt_pkg::ST_ALARM: begin
        if (guard_event) begin
          irq_next = 1'b1;
        end else if (cmd_clear && !guard_run) begin
          state_next = wwt_pkg::ST_IDLE; // [R10]
        end
      end
      wwt_pkg::ST_HOLD: begin
        // request repeats until the self reset lands, which is harmless
        if (hold_reg == 5'(wwt_pkg::HOLD_CYC - 1)) begin
          rst_req_next = 1'b1; // [R15]
        end else begin
          hold_next = hold_reg + 5'd1;
        end
      end
      default: begin
        state_next = wwt_pkg::ST_IDLE;
      end
    endcase
    alarm_n_next = (state_next == wwt_pkg::ST_IDLE); // [R7]
  end

  // self reset returns the core registers to their power-on state one cycle after the request; the bus slave registers keep their state
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && rst_req_reg)) begin
      mode_reg       <= wwt_pkg::MODE_RESET[7:1]; // [R4] [R11] [R14]
      quick_reg      <= 1'b0;
      disarm_reg     <= 1'b0;
      pre_reg        <= '0;
      cnt_reg        <= '0;
      state_reg      <= wwt_pkg::ST_IDLE;
      hold_reg       <= 5'd0;
      warm_reg       <= 1'b0;
      wdone_reg      <= 1'b0;
      wdone_flag_reg <= 1'b0;
      irq_reg        <= 1'b0;
      alarm_n_reg    <= 1'b1;
      rst_req_reg    <= 1'b0;
    end else if (ce) begin
      mode_reg       <= mode_next;
      quick_reg      <= quick_next;
      disarm_reg     <= disarm_next;
      pre_reg        <= pre_next;
      cnt_reg        <= cnt_next;
      state_reg      <= state_next;
      hold_reg       <= hold_next;
      warm_reg       <= warm_next;
      wdone_reg      <= wdone_next;
      wdone_flag_reg <= wdone_flag_next;
      irq_reg        <= irq_next;
      alarm_n_reg    <= alarm_n_next;
      rst_req_reg    <= rst_req_next;
    end
  end

  assign s_axi_awready       = awready_reg;
  assign s_axi_wready        = wready_reg;
  assign s_axi_bvalid        = bvalid_reg;
  assign s_axi_bresp         = bresp_reg;
  assign s_axi_arready       = arready_reg;
  assign s_axi_rvalid        = rvalid_reg;
  assign s_axi_rdata         = rdata_reg;
  assign s_axi_rresp         = rresp_reg;
  assign warmup_done         = wdone_reg;
  assign guard_overflow_irq  = irq_reg;
  assign runaway_alarm_out_n = alarm_n_reg;
  assign chip_reset_req      = rst_req_reg;

endmodule

// ### core/wwt_pkg.sv
package wwt_pkg;

  // register byte addresses
  localparam logic [3:0] MODE_OFS   = 4'h0;
  localparam logic [3:0] CMD_OFS    = 4'h4;
  localparam logic [3:0] PAIR_OFS   = 4'h8;
  localparam logic [3:0] STATUS_OFS = 4'hc;

  // mode register fields
  localparam int MODE_ENABLE_BIT = 7;
  localparam int MODE_PERIOD_LSB = 5;
  localparam int MODE_WARM_BIT   = 4;
  localparam int MODE_STBY_LSB   = 2;
  localparam int MODE_RLINK_BIT  = 1;
  localparam logic [7:0] MODE_RESET = 8'h80;

  // timer pair control field
  localparam int PAIR_QUICK_BIT = 0;

  // status register fields
  localparam int STAT_RUN_BIT   = 0;
  localparam int STAT_ALARM_BIT = 1;
  localparam int STAT_WARM_BIT  = 2;
  localparam int STAT_DONE_BIT  = 3;
  localparam int STAT_CNT_LSB   = 16;

  // command codes
  localparam logic [7:0] CMD_CLEAR   = 8'h4e;
  localparam logic [7:0] CMD_DISABLE = 8'hb1;

  // chain geometry
  localparam int PRE_STAGES  = 7;
  localparam int CNT_STAGES  = 15;
  localparam int TAP_BASE    = 8;
  localparam int TAP_STEP    = 2;
  localparam int WARM_SHORT  = 7;
  localparam int WARM_LONG   = 9;

  // alarm hold before self reset, in states (8 to 20 allowed)
  localparam int HOLD_STATES   = 12;
  localparam int CYC_PER_STATE = 1;
  localparam int HOLD_CYC      = HOLD_STATES * CYC_PER_STATE;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ALARM = 3'b010,
    ST_HOLD  = 3'b100
  } wwt_state_t;

  typedef struct packed {
    logic       enable;
    logic [1:0] period;
    logic       warm_sel;
    logic [1:0] standby;
    logic       rlink;
  } wwt_mode_t;

endpackage

// ### dv/wwt_monitor.sv
`timescale 1ns/1ps
module wwt_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic light_idle_mode,
  input wire logic stop_mode,
  input wire logic deep_idle_mode,
  input wire logic guard_overflow_irq,
  input wire logic runaway_alarm_out_n,
  input wire logic chip_reset_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_irq_alarm;
    guard_overflow_irq |-> !runaway_alarm_out_n;
  endproperty
  a_irq_alarm: assert property (p_irq_alarm) else $error("irq without alarm");

  property p_alarm_fall;
    $fell(runaway_alarm_out_n) |-> guard_overflow_irq;
  endproperty
  a_alarm_fall: assert property (p_alarm_fall) else $error("alarm without irq");

  property p_rst_vals;
    $rose(aresetn) |-> runaway_alarm_out_n && !guard_overflow_irq && !chip_reset_req;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("outputs not idle");

  // lower bound only: an alarm without the link may stay low for ever
  property p_hold_min;
    chip_reset_req |-> $past(runaway_alarm_out_n, 8) == 1'b0;
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("alarm hold too short");

  property p_self_reset;
    chip_reset_req |-> ##[1:2] runaway_alarm_out_n;
  endproperty
  a_self_reset: assert property (p_self_reset) else $error("alarm kept after reset");

  property p_deep;
    $past(deep_idle_mode) |-> !guard_overflow_irq;
  endproperty
  a_deep: assert property (p_deep) else $error("irq in deep idle");

  property p_halt;
    $past(light_idle_mode) || $past(stop_mode) |-> !guard_overflow_irq;
  endproperty
  a_halt: assert property (p_halt) else $error("irq while halted");

  property p_alarm_rise;
    $rose(runaway_alarm_out_n) |->
      s_axi_bvalid || $past(chip_reset_req) || $past(chip_reset_req, 2);
  endproperty
  a_alarm_rise: assert property (p_alarm_rise) else $error("alarm left early");
endmodule

bind wwt_top wwt_monitor i_mon (
  .aclk                (aclk),
  .aresetn             (aresetn),
  .s_axi_bvalid        (s_axi_bvalid),
  .light_idle_mode     (light_idle_mode),
  .stop_mode           (stop_mode),
  .deep_idle_mode      (deep_idle_mode),
  .guard_overflow_irq  (guard_overflow_irq),
  .runaway_alarm_out_n (runaway_alarm_out_n),
  .chip_reset_req      (chip_reset_req)
);

// ### dv/wwt_periph_model.sv
`timescale 1ns/1ps
module wwt_periph_model (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       runaway_alarm_out_n,
  input wire logic       chip_reset_req,
  output logic     [7:0] hold_len
);
  logic [7:0] low_run;

  // peripheral held in reset by the alarm pin, measures the hold
  always @(posedge aclk) begin
    if (!aresetn) begin
      low_run  <= 8'h00;
      hold_len <= 8'h00;
    end else begin
      low_run <= runaway_alarm_out_n ? 8'h00 : low_run + 8'h01;
      if (chip_reset_req) begin
        hold_len <= low_run;
      end
    end
  end
endmodule

// ### dv/wwt_top_tb.sv
`timescale 1ns/1ps
module wwt_top_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        light, stop, deep, wstart, wdone, irq, alarm_n, rst_req, ce;
  logic [1:0]  bresp, rresp, br, rr;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, e;
  logic [7:0]  hold_len;
  logic [2:0]  evt;
  int          num_errors, comparisons, cyc, n;

  assign evt = {rst_req, irq, wdone};

  wwt_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .light_idle_mode(light),
    .stop_mode(stop), .deep_idle_mode(deep), .warmup_start(wstart),
    .warmup_done(wdone), .guard_overflow_irq(irq),
    .runaway_alarm_out_n(alarm_n), .chip_reset_req(rst_req)
  );

  wwt_periph_model i_per (
    .aclk(aclk), .aresetn(aresetn), .runaway_alarm_out_n(alarm_n), .chip_reset_req(rst_req),
    .hold_len(hold_len)
  );

  always #10 aclk = ~aclk;

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    br = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    rr = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wait_evt(input int k, input int lim);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (evt[k] !== 1'b1 && n < lim);
  endtask

  task automatic warm_pulse;
    wstart <= 1'b1;
    @(posedge aclk);
    wstart <= 1'b0;
    wait_evt(0, 20000);
  endtask

  // every overflow costs 2^15 cycles, so the ceiling sits above two of them
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 95000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, light, stop, deep, wstart} = '0;
    {awaddr, araddr, wdata} = '0;
    ce = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(wwt_pkg::MODE_OFS, d);
    chk("mode", d, {24'h000000, wwt_pkg::MODE_RESET});
    chk("rresp", rr, wwt_pkg::RESP_OKAY);
    repeat (300) @(posedge aclk);
    rd(wwt_pkg::STATUS_OFS, d);
    chk("run", d[0], 1'b1);
    chk("count", d[30:16] != 15'h0000, 1'b1);
    wr(wwt_pkg::CMD_OFS, wwt_pkg::CMD_DISABLE);
    rd(wwt_pkg::STATUS_OFS, d);
    chk("run", d[0], 1'b1);
    wr(wwt_pkg::MODE_OFS, 8'h00);
    wr(wwt_pkg::CMD_OFS, wwt_pkg::CMD_DISABLE);
    chk("bresp", br, wwt_pkg::RESP_OKAY);
    rd(wwt_pkg::STATUS_OFS, d);
    chk("run", d[0], 1'b0);
    wr(wwt_pkg::MODE_OFS, 8'h80);
    rd(wwt_pkg::STATUS_OFS, d);
    chk("run", d[0], 1'b1);
    wr(wwt_pkg::CMD_OFS, wwt_pkg::CMD_CLEAR);
    rd(wwt_pkg::STATUS_OFS, d);
    chk("count", d[30:16], 15'h0000);
    // light idle, stop, then deep idle
    for (int i = 0; i < 3; i++) begin
      {deep, stop, light} <= 3'b001 << i;
      rd(wwt_pkg::STATUS_OFS, d);
      repeat (300) @(posedge aclk);
      rd(wwt_pkg::STATUS_OFS, e);
      chk("frozen", d[30:16] == e[30:16], i < 2);
    end
    {deep, stop, light} <= 3'b000;
    // clock enable low must freeze the chain: at most one step outside the gap
    rd(wwt_pkg::STATUS_OFS, d);
    ce <= 1'b0;
    repeat (300) @(posedge aclk);
    ce <= 1'b1;
    rd(wwt_pkg::STATUS_OFS, e);
    chk("ce freeze", (e[30:16] - d[30:16]) <= 15'h0001, 1'b1);
    wr(wwt_pkg::MODE_OFS, 8'h00);
    wr(wwt_pkg::CMD_OFS, wwt_pkg::CMD_DISABLE);
    wr(wwt_pkg::PAIR_OFS, 8'h01);
    warm_pulse();
    chk("quick", n >= 126 && n <= 132, 1'b1);
    wr(wwt_pkg::MODE_OFS, 8'h80);
    warm_pulse();
    chk("warm", n >= 16380 && n <= 16400, 1'b1);
    wr(wwt_pkg::PAIR_OFS, 8'h00);
    wr(wwt_pkg::CMD_OFS, wwt_pkg::CMD_CLEAR);
    wait_evt(1, 40000);
    chk("timeout", n >= 32740 && n <= 32770, 1'b1);
    chk("alarm", alarm_n, 1'b0);
    wr(wwt_pkg::CMD_OFS, wwt_pkg::CMD_CLEAR);
    chk("alarm", alarm_n, 1'b0);
    wr(wwt_pkg::MODE_OFS, 8'h00);
    wr(wwt_pkg::CMD_OFS, wwt_pkg::CMD_DISABLE);
    wr(wwt_pkg::CMD_OFS, wwt_pkg::CMD_CLEAR);
    chk("alarm", alarm_n, 1'b1);
    chk("no reset", hold_len, 8'h00);
    wr(wwt_pkg::MODE_OFS, 8'h82);
    wr(wwt_pkg::CMD_OFS, wwt_pkg::CMD_CLEAR);
    wait_evt(2, 40000);
    repeat (3) @(posedge aclk);
    chk("hold", hold_len >= 8'd8 && hold_len <= 8'd20, 1'b1);
    rd(wwt_pkg::MODE_OFS, d);
    chk("mode", d, {24'h000000, wwt_pkg::MODE_RESET});
    print_verdict();
  end
endmodule
